/* File: hw/sbsi_burst_ctr.sv */
// Two-bit burst address counter with linear or interleaved order.
`timescale 1ns/1ps
`default_nettype none
module sbsi_burst_ctr
	import sbsi_pkg::*;
(
	input  wire logic                    ref_clk,
	input  wire logic                    rstn,
	input  wire logic                    load,
	input  wire logic                    advance,
	input  wire logic                    interleave,
	input  wire logic [SBSI_BURST_W-1:0] start,
	output logic      [SBSI_BURST_W-1:0] low_addr_bits
);
	logic [SBSI_BURST_W-1:0] start_ff;
	logic [SBSI_BURST_W-1:0] count_ff;
	logic [SBSI_BURST_W-1:0] nxt_count;
	logic [SBSI_BURST_W-1:0] base;

	always_comb begin
		nxt_count = count_ff;
		if (load) begin
			nxt_count = SBSI_CNT_RST; // R6
		end else if (advance) begin
			nxt_count = count_ff + SBSI_CNT_STEP; // R4
		end
	end

	assign base = load ? start : start_ff; // R6
	// Interleaved order flips bits of the start; linear order adds and wraps in four.
	assign low_addr_bits = interleave ? (base ^ nxt_count) : (base + nxt_count); // R5 R7

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			start_ff <= SBSI_CNT_RST;
		end else if (load) begin
			start_ff <= start;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			count_ff <= SBSI_CNT_RST;
		end else begin
			count_ff <= nxt_count;
		end
	end
endmodule // sbsi_burst_ctr
`default_nettype wire

/* File: hw/sbsi_device.sv */
// Memory end: synchronous burst static RAM with flow-through or pipelined reads.
// Summary of operation
// R1 - Inputs sampled on rising clock edge.
// R2 - Output enable and sleep act asynchronously.
// R3 - Either address strobe starts a burst.
// R4 - Counter steps only when advance sampled low.
// R5 - Two-bit counter, four-word burst.
// R6 - Low address bits preset the counter.
// R7 - Order pin low linear, high interleaved.
// R8 - Unconnected modes give interleaved pipelined.
// R9 - Fresh address every cycle at full rate.
// R10 - Flow-through select low bypasses output register.
// R11 - Flow-through select high registers read data.
// R12 - Deselect delayed like a read.
// R13 - Outputs drop after second edge past deselect.
// R14 - Byte write writes only selected lanes.
// R15 - Global write writes every lane.
// R16 - Writes complete internally on the sampling edge.
// R17 - Sleep on sleep pin or stopped clock.
// R18 - Contents kept during sleep.
// R19 - Selected only with all enables asserted.
// R20 - Data driven only with output enable low.
// R21 - Both address strobes are active low.
// R22 - Unconnected pins default pipelined and awake.
// R23 - Data drivers off during any write.
//
`timescale 1ns/1ps
`default_nettype none
module sbsi_device
	import sbsi_pkg::*;
(
	sbsi_if.dev_mp bus,
	input  wire logic rstn,
	input  wire logic flow_through_select_n,
	input  wire logic flow_through_driven,
	input  wire logic linear_order_select_n,
	input  wire logic linear_order_driven,
	input  wire logic sleep_request,
	input  wire logic sleep_driven,
	output logic      asleep,
	output logic      pipelined
);
	logic [SBSI_DATA_W-1:0]   mem [SBSI_DEPTH];
	logic                     ref_clk;
	logic                     interleave;
	logic                     selected;
	logic                     strobe;
	logic                     go_load;
	logic                     go_desel;
	logic                     go_cont;
	logic                     advance;
	logic [SBSI_LANES-1:0]    wr_mask;
	logic                     wr_cyc;
	logic                     rd_cyc;
	logic [SBSI_BURST_W-1:0]  ctr_low;
	logic [SBSI_ADDR_W-1:0]   cyc_addr;
	logic [SBSI_DATA_W-1:0]   array_q;
	logic                     drive;
	logic                     active_cyc;
	logic                     oe_ok;
	sbsi_sess_e               sess_ff;
	sbsi_sess_e               nxt_sess;
	logic [SBSI_ADDR_W-1:SBSI_BURST_W] hi_addr_ff;
	logic [SBSI_ADDR_W-1:0]   rd_addr_ff;
	logic                     act1_ff;
	logic                     act2_ff;
	logic [SBSI_DATA_W-1:0]   out_ff;

	assign ref_clk = bus.ref_clk;

	// A pin left open falls back to the level of its on-die pull.
	assign pipelined  = flow_through_driven ? flow_through_select_n : SBSI_FT_N_DFLT; // R8 R22
	assign interleave = linear_order_driven ? linear_order_select_n : SBSI_LBO_N_DFLT; // R7 R8
	// Sleep gates commands and drivers without waiting for an edge.
	assign asleep     = sleep_driven ? sleep_request : SBSI_SLEEP_DFLT; // R2 R17 R22

	assign selected = bus.select_high & ~bus.select_low_a_n & ~bus.select_low_b_n; // R19
	assign strobe   = ~bus.cpu_addr_strobe_n | ~bus.ctrl_addr_strobe_n; // R3 R21

	// Every strobe may carry a new address, so no cycle is lost to reloading.
	assign go_load  = ~asleep & strobe & selected; // R3 R9
	assign go_desel = ~asleep & strobe & ~selected; // R19
	assign go_cont  = ~asleep & ~strobe & (sess_ff == SBSI_SESS_OPEN);
	assign advance  = go_cont & ~bus.burst_advance_n; // R4
	// Only a load or a continue cycle is a real access that may read or write.
	assign active_cyc = go_load | go_cont;

	// Load cycles may write as well, so a single strobe can carry a store.
	always_comb begin
		wr_mask = '0;
		if (active_cyc) begin
			wr_mask = sbsi_lane_mask(bus.all_bytes_write_n, bus.byte_write_gate_n,
				bus.lane_write_n); // R14 R15
		end
	end

	assign wr_cyc = |wr_mask;
	assign rd_cyc = active_cyc & ~wr_cyc;

	sbsi_burst_ctr u_ctr (
		.ref_clk       (ref_clk),
		.rstn          (rstn),
		.load          (go_load),
		.advance       (advance),
		.interleave    (interleave),
		.start         (bus.addr[SBSI_BURST_W-1:0]),
		.low_addr_bits (ctr_low)
	);

	// Continue cycles reuse the held upper bits beside the counter's low bits.
	assign cyc_addr = go_load ? bus.addr : {hi_addr_ff, ctr_low}; // R4 R6

	// A deselect closes the session, so later idle cycles no longer re-read.
	always_comb begin
		nxt_sess = sess_ff;
		case (sess_ff)
			SBSI_SESS_IDLE: begin
				if (go_load) begin
					nxt_sess = SBSI_SESS_OPEN;
				end
			end
			SBSI_SESS_OPEN: begin
				if (go_desel) begin
					nxt_sess = SBSI_SESS_IDLE;
				end
			end
			default: begin
				nxt_sess = SBSI_SESS_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			sess_ff <= SBSI_SESS_IDLE;
		end else begin
			sess_ff <= nxt_sess; // R1
		end
	end

	// Only a load moves the upper bits; a burst never carries past four words.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			hi_addr_ff <= SBSI_ADDR_RST[SBSI_ADDR_W-1:SBSI_BURST_W];
		end else if (go_load) begin
			hi_addr_ff <= bus.addr[SBSI_ADDR_W-1:SBSI_BURST_W]; // R1
		end
	end

	// The array has no reset and ignores sleep, so contents survive both.
	always_ff @(posedge ref_clk) begin
		for (int i = 0; i < SBSI_LANES; i++) begin
			if (wr_mask[i]) begin
				mem[cyc_addr][i*SBSI_LANE_W +: SBSI_LANE_W] <=
					bus.dq_wire[i*SBSI_LANE_W +: SBSI_LANE_W]; // R14 R15 R16 R18
			end
		end
	end

	// The read address is held, so the array output stays put between reads.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rd_addr_ff <= SBSI_ADDR_RST;
		end else if (rd_cyc) begin
			rd_addr_ff <= cyc_addr; // R1
		end
	end

	// Flow-through mode shows this word on the pins directly.
	assign array_q = mem[rd_addr_ff];

	// Stage one follows the command; stage two delays it once more.
	// A stopped clock freezes both stages, which is the clock-stop sleep.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			act1_ff <= 1'h0;
		end else if (!asleep) begin
			act1_ff <= rd_cyc; // R12 R17
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			act2_ff <= 1'h0;
		end else if (!asleep) begin
			act2_ff <= act1_ff; // R12 R13
		end
	end

	// The output register loads only behind a read, so a deselect keeps its word.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			out_ff <= SBSI_DATA_RST;
		end else if (!asleep && act1_ff) begin
			out_ff <= array_q; // R11
		end
	end

	// Flow-through drives from the read stage and holds one more cycle on deselect.
	assign drive = pipelined ? act2_ff : (act1_ff | act2_ff); // R10 R11 R13
	// Output enable and sleep reach the drivers without waiting for an edge.
	assign oe_ok = ~bus.out_enable_n & ~asleep; // R2 R20
	// Gating on the live write controls frees the wire for the master's data.
	// Read data that fall in a write cycle are lost, so masters leave a gap.
	assign bus.dq_dev_oe = drive & oe_ok & ~wr_cyc; // R23
	assign bus.dq_dev    = pipelined ? out_ff : array_q; // R10 R11
endmodule // sbsi_device
`default_nettype wire

/* File: hw/sbsi_host.sv */
// Master end: turns one user request per cycle into registered memory pin activity.
`timescale 1ns/1ps
`default_nettype none
module sbsi_host
	import sbsi_pkg::*;
(
	sbsi_if.host_mp bus,
	input  wire logic                   rstn,
	input  wire logic                   pipelined,
	input  wire logic                   req_valid,
	input  wire logic                   req_write,
	input  wire logic                   req_burst,
	input  wire logic                   req_deselect,
	input  wire logic                   req_use_ctrl,
	input  wire logic                   req_all_lanes,
	input  wire logic [SBSI_LANES-1:0]  req_lanes,
	input  wire logic [SBSI_ADDR_W-1:0] req_addr,
	input  wire logic [SBSI_DATA_W-1:0] req_wdata,
	output logic      [SBSI_DATA_W-1:0] rd_data,
	output logic                        rd_valid
);
	logic                     ref_clk;
	logic                     new_addr;
	logic                     is_rd;
	logic [SBSI_RD_SR_W-1:0]  rd_sr_ff;
	logic                     capture;

	assign ref_clk  = bus.ref_clk;
	assign new_addr = req_valid & ~req_burst;
	assign is_rd    = req_valid & ~req_write & ~req_deselect;

	// Every pin changes only right after an edge, ready for the next one.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			bus.addr               <= SBSI_ADDR_RST;
			bus.cpu_addr_strobe_n  <= 1'h1;
			bus.ctrl_addr_strobe_n <= 1'h1;
			bus.burst_advance_n    <= 1'h1;
			bus.select_low_a_n     <= 1'h1;
			bus.select_low_b_n     <= 1'h1;
			bus.select_high        <= 1'h0;
		end else begin
			bus.cpu_addr_strobe_n  <= ~(new_addr & ~req_use_ctrl); // R1 R3 R9
			bus.ctrl_addr_strobe_n <= ~(new_addr & req_use_ctrl); // R3
			bus.burst_advance_n    <= ~(req_valid & req_burst);
			bus.select_low_a_n     <= req_deselect; // R19
			bus.select_low_b_n     <= req_deselect; // R19
			bus.select_high        <= ~req_deselect; // R19
			if (new_addr) begin
				bus.addr <= req_addr; // R9
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			bus.all_bytes_write_n <= 1'h1;
			bus.byte_write_gate_n <= 1'h1;
			bus.lane_write_n      <= SBSI_LANES_OFF_N;
			bus.dq_host           <= SBSI_DATA_RST;
			bus.dq_host_oe        <= 1'h0;
			bus.out_enable_n      <= 1'h0;
		end else begin
			bus.all_bytes_write_n <= ~(req_valid & req_write & req_all_lanes);
			bus.byte_write_gate_n <= ~(req_valid & req_write & ~req_all_lanes);
			bus.lane_write_n      <= ~req_lanes;
			bus.dq_host           <= req_wdata; // R1
			bus.dq_host_oe        <= req_valid & req_write & ~req_deselect;
			// Output enable is lifted during writes so the wire is never fought over.
			bus.out_enable_n      <= req_valid & req_write;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rd_sr_ff <= '0;
		end else begin
			rd_sr_ff <= {rd_sr_ff[SBSI_RD_SR_W-2:0], is_rd};
		end
	end

	assign capture = pipelined ? rd_sr_ff[SBSI_CAP_PL] : rd_sr_ff[SBSI_CAP_FT];

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rd_data  <= SBSI_DATA_RST;
			rd_valid <= 1'h0;
		end else begin
			rd_valid <= capture;
			if (capture) begin
				rd_data <= bus.dq_wire;
			end
		end
	end
endmodule // sbsi_host
`default_nettype wire

/* File: include/sbsi_if.sv */
// Pin-level carrier between the bus master and the burst memory.
`timescale 1ns/1ps
`default_nettype none
interface sbsi_if
	import sbsi_pkg::*;
(
	input wire logic ref_clk
);
	logic [SBSI_ADDR_W-1:0] addr;
	logic                   select_low_a_n;
	logic                   select_high;
	logic                   select_low_b_n;
	logic                   cpu_addr_strobe_n;
	logic                   ctrl_addr_strobe_n;
	logic                   burst_advance_n;
	logic                   byte_write_gate_n;
	logic                   all_bytes_write_n;
	logic [SBSI_LANES-1:0]  lane_write_n;
	logic                   out_enable_n;
	logic [SBSI_DATA_W-1:0] dq_host;
	logic                   dq_host_oe;
	logic [SBSI_DATA_W-1:0] dq_dev;
	logic                   dq_dev_oe;
	logic [SBSI_DATA_W-1:0] dq_wire;

	// The memory wins the shared data wire only while it drives.
	assign dq_wire = dq_dev_oe ? dq_dev : dq_host;

	modport dev_mp (
		input  ref_clk,
		input  addr,
		input  select_low_a_n,
		input  select_high,
		input  select_low_b_n,
		input  cpu_addr_strobe_n,
		input  ctrl_addr_strobe_n,
		input  burst_advance_n,
		input  byte_write_gate_n,
		input  all_bytes_write_n,
		input  lane_write_n,
		input  out_enable_n,
		input  dq_wire,
		output dq_dev,
		output dq_dev_oe
	);

	modport host_mp (
		input  ref_clk,
		output addr,
		output select_low_a_n,
		output select_high,
		output select_low_b_n,
		output cpu_addr_strobe_n,
		output ctrl_addr_strobe_n,
		output burst_advance_n,
		output byte_write_gate_n,
		output all_bytes_write_n,
		output lane_write_n,
		output out_enable_n,
		output dq_host,
		output dq_host_oe,
		input  dq_wire
	);
endinterface
`default_nettype wire

/* File: include/sbsi_pkg.sv */
// Shared constants, types and decode helpers for the synchronous burst memory link.
package sbsi_pkg;
	localparam int SBSI_ADDR_W  = 18;
	localparam int SBSI_DATA_W  = 36;
	localparam int SBSI_LANES   = 4;
	localparam int SBSI_LANE_W  = 9;
	localparam int SBSI_BURST_W = 2;
	localparam int SBSI_DEPTH   = 2 ** SBSI_ADDR_W;
	// Levels that the on-die pulls give an unconnected mode pin.
	localparam logic SBSI_FT_N_DFLT  = 1'h1;
	localparam logic SBSI_LBO_N_DFLT = 1'h1;
	localparam logic SBSI_SLEEP_DFLT = 1'h0;
	// Read-flag shift stage that the host samples in each output mode.
	localparam int SBSI_CAP_FT = 1;
	localparam int SBSI_CAP_PL = 2;
	localparam int SBSI_RD_SR_W = 3;
	localparam logic [SBSI_DATA_W-1:0]  SBSI_DATA_RST = 36'h000000000;
	localparam logic [SBSI_ADDR_W-1:0]  SBSI_ADDR_RST = 18'h00000;
	localparam logic [SBSI_LANES-1:0]   SBSI_LANES_OFF_N = 4'hF;
	localparam logic [SBSI_BURST_W-1:0] SBSI_CNT_RST = 2'h0;
	localparam logic [SBSI_BURST_W-1:0] SBSI_CNT_STEP = 2'h1;

	typedef enum logic [1:0] {
		SBSI_SESS_IDLE = 2'b01,
		SBSI_SESS_OPEN = 2'b10
	} sbsi_sess_e;

	// Active-high lane mask from the three active-low write controls.
	function automatic logic [SBSI_LANES-1:0] sbsi_lane_mask(
		input logic                  all_n,
		input logic                  gate_n,
		input logic [SBSI_LANES-1:0] lane_n
	);
		logic [SBSI_LANES-1:0] m;
		m = '0;
		if (!all_n) begin
			m = '1;
		end else if (!gate_n) begin
			m = ~lane_n;
		end
		return m;
	endfunction
endpackage

/* File: testbench/sbsi_monitor.sv */
// Pin-level checks on the link between the master end and the memory end.
`timescale 1ns/1ps
`default_nettype none
module sbsi_monitor
	import sbsi_pkg::*;
(
	input wire logic                  ref_clk,
	input wire logic                  rstn,
	input wire logic                  select_low_a_n,
	input wire logic                  select_high,
	input wire logic                  select_low_b_n,
	input wire logic                  cpu_addr_strobe_n,
	input wire logic                  ctrl_addr_strobe_n,
	input wire logic                  all_bytes_write_n,
	input wire logic                  byte_write_gate_n,
	input wire logic [SBSI_LANES-1:0] lane_write_n,
	input wire logic                  out_enable_n,
	input wire logic                  dq_host_oe,
	input wire logic                  dq_dev_oe
);
	logic sel;
	logic stb;
	logic wr;
	logic rd;
	logic desel;
	assign sel = !select_low_a_n && select_high && !select_low_b_n;
	assign stb = !cpu_addr_strobe_n || !ctrl_addr_strobe_n;
	assign wr = !all_bytes_write_n || (!byte_write_gate_n && lane_write_n != 4'hF);
	assign rd = stb && sel && !wr;
	assign desel = stb && !sel;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	property p_oe_gate; out_enable_n |-> !dq_dev_oe; endproperty
	a_oe_gate: assert property (p_oe_gate)
		else $error("memory drives with output enable off");
	property p_wr_quiet; wr |-> !dq_dev_oe; endproperty
	a_wr_quiet: assert property (p_wr_quiet)
		else $error("memory drives during a write");
	property p_host_yield; dq_host_oe |-> out_enable_n; endproperty
	a_host_yield: assert property (p_host_yield)
		else $error("master drives data with output enable on");
	property p_wr_data; wr |-> dq_host_oe; endproperty
	a_wr_data: assert property (p_wr_data)
		else $error("write controls without write data");
	property p_rd_drive; rd ##1 (!out_enable_n && !wr) [*2] |-> dq_dev_oe; endproperty
	a_rd_drive: assert property (p_rd_drive)
		else $error("read data not driven in time");
	property p_desel_hold; rd ##1 desel ##1 (!out_enable_n && !wr) |-> dq_dev_oe; endproperty
	a_desel_hold: assert property (p_desel_hold)
		else $error("outputs released too early after deselect");
	property p_desel_drop; desel ##1 !(stb && sel) |-> ##1 !dq_dev_oe; endproperty
	a_desel_drop: assert property (p_desel_drop)
		else $error("outputs still driven late after deselect");
	property p_desel_dead; desel ##1 !stb ##1 !stb |-> ##1 !dq_dev_oe; endproperty
	a_desel_dead: assert property (p_desel_dead)
		else $error("burst continued after deselect");
endmodule // sbsi_monitor
`default_nettype wire

/* File: testbench/tb_sync_burst_sram_interface.sv */
// Self-checking bench joining the master end to the memory end.
`timescale 1ns/1ps
`default_nettype none
module tb_sync_burst_sram_interface
	import sbsi_pkg::*;
;
	logic ref_clk = 1'b0;
	logic rstn, flow_through_select_n, flow_through_driven, linear_order_select_n;
	logic linear_order_driven, sleep_request, sleep_driven, asleep, pipelined;
	logic req_valid, req_write, req_burst, req_deselect, req_use_ctrl, req_all_lanes;
	logic [3:0]  req_lanes;
	logic [17:0] req_addr;
	logic [35:0] req_wdata, rd_data;
	logic        rd_valid;
	logic [35:0] m [4];
	logic [35:0] eq [$];
	logic [35:0] rq [$];
	int          error_cnt = 0;
	int          checked = 0;
	int          cyc = 0;

	sbsi_if bus_if (.ref_clk(ref_clk));
	sbsi_device sbsi_device_inst (.bus(bus_if), .rstn(rstn),
		.flow_through_select_n(flow_through_select_n), .flow_through_driven(flow_through_driven),
		.linear_order_select_n(linear_order_select_n), .linear_order_driven(linear_order_driven),
		.sleep_request(sleep_request), .sleep_driven(sleep_driven), .asleep(asleep),
		.pipelined(pipelined));
	sbsi_host sbsi_host_inst (.bus(bus_if), .rstn(rstn), .pipelined(pipelined),
		.req_valid(req_valid), .req_write(req_write), .req_burst(req_burst),
		.req_deselect(req_deselect), .req_use_ctrl(req_use_ctrl), .req_all_lanes(req_all_lanes),
		.req_lanes(req_lanes), .req_addr(req_addr), .req_wdata(req_wdata), .rd_data(rd_data),
		.rd_valid(rd_valid));
	sbsi_monitor sbsi_monitor_inst (.ref_clk(ref_clk), .rstn(rstn),
		.select_low_a_n(bus_if.select_low_a_n), .select_high(bus_if.select_high),
		.select_low_b_n(bus_if.select_low_b_n), .cpu_addr_strobe_n(bus_if.cpu_addr_strobe_n),
		.ctrl_addr_strobe_n(bus_if.ctrl_addr_strobe_n),
		.all_bytes_write_n(bus_if.all_bytes_write_n),
		.byte_write_gate_n(bus_if.byte_write_gate_n), .lane_write_n(bus_if.lane_write_n),
		.out_enable_n(bus_if.out_enable_n), .dq_host_oe(bus_if.dq_host_oe),
		.dq_dev_oe(bus_if.dq_dev_oe));

	always #12.5 ref_clk = ~ref_clk;

	// Sampled mid-cycle so the registered pulse has settled.
	always @(negedge ref_clk) if (rd_valid === 1'b1) rq.push_back(rd_data);

	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			error_cnt++;
			finish_test();
		end
	end

	task automatic finish_test();
		if (error_cnt == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk_d(input string nm, input logic [35:0] e, input logic [35:0] g);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic chk_f(input string nm, input logic e, input logic g);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %s exp %b got %b", nm, e, g);
		end
	endtask

	function automatic logic [35:0] pat(input int i);
		return 36'h123456789 + 36'(i) * 36'h011111111;
	endfunction

	task automatic idle(input int n);
		repeat (n) begin
			@(posedge ref_clk);
			req_valid <= 1'b0;
		end
	endtask

	// The expected image is updated lane by lane as each write is issued.
	task automatic op(input logic w, b, d, c, g, input logic [3:0] ln, input logic [17:0] a,
			input logic [35:0] wd);
		@(posedge ref_clk);
		req_valid <= 1'b1;
		req_write <= w;
		req_burst <= b;
		req_deselect <= d;
		req_use_ctrl <= c;
		req_all_lanes <= g;
		req_lanes <= ln;
		req_addr <= a;
		req_wdata <= wd;
		for (int l = 0; l < 4; l++)
			if (w && (g || ln[l])) m[a[1:0]][9*l+:9] = wd[9*l+:9];
	endtask

	task automatic rd(input logic [17:0] a, input logic c);
		op(1'b0, 1'b0, 1'b0, c, 1'b0, 4'h0, a, 36'h0);
		eq.push_back(m[a[1:0]]);
	endtask

	task automatic bst(input logic [1:0] lo);
		op(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 4'h0, 18'h0, 36'h0);
		eq.push_back(m[lo]);
	endtask

	task automatic drain();
		idle(8);
		chk_d("rd_count", 36'(eq.size()), 36'(rq.size()));
		while (eq.size() > 0)
			chk_d("rd_data", eq.pop_front(), rq.size() > 0 ? rq.pop_front() : 36'hX);
		rq.delete();
	endtask

	initial begin
		rstn = 1'b0;
		{req_valid, req_write, req_burst, req_deselect, req_use_ctrl, req_all_lanes} = 6'h00;
		req_lanes = 4'h0;
		req_addr = 18'h0;
		req_wdata = 36'h0;
		{flow_through_select_n, linear_order_select_n, sleep_request} = 3'h0;
		{flow_through_driven, linear_order_driven, sleep_driven} = 3'h7;
		repeat (6) @(posedge ref_clk);
		rstn <= 1'b1;
		idle(2);
		chk_f("pipelined", 1'b0, pipelined);
		for (int i = 0; i < 4; i++)
			op(1'b1, 1'b0, 1'b0, i[0], 1'b1, 4'h0, 18'h00100 + 18'(i), pat(i));
		for (int i = 0; i < 4; i++)
			rd(18'h00100 + 18'(i), i[1]);
		op(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 4'h0, 18'h0, 36'h0);
		drain();
		op(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 4'h5, 18'h00101, 36'hFFFFFFFFF);
		op(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 4'h0, 18'h00102, 36'h0C0FFEE00);
		rd(18'h00101, 1'b0);
		rd(18'h00102, 1'b1);
		drain();
		// Linear burst from word 1, with a pause that must not step the counter.
		rd(18'h00101, 1'b0);
		bst(2'h2);
		idle(1);
		bst(2'h3);
		bst(2'h0);
		drain();
		flow_through_driven <= 1'b0;
		linear_order_driven <= 1'b0;
		idle(1);
		chk_f("pipelined", 1'b1, pipelined);
		rd(18'h00102, 1'b1);
		bst(2'h3);
		bst(2'h0);
		bst(2'h1);
		// Pipelined read data trail their command, so the write waits two cycles.
		idle(2);
		op(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 4'h0, 18'h00103, pat(9));
		rd(18'h00103, 1'b0);
		drain();
		@(posedge ref_clk);
		sleep_request <= 1'b1;
		#2;
		chk_f("asleep", 1'b1, asleep);
		idle(1);
		op(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 4'h0, 18'h00100, pat(7));
		// A sleeping memory ignores the store, so the image keeps the old word.
		m[0] = pat(0);
		idle(3);
		chk_f("asleep", 1'b1, asleep);
		sleep_driven <= 1'b0;
		#2;
		chk_f("asleep", 1'b0, asleep);
		rd(18'h00100, 1'b1);
		drain();
		finish_test();
	end
endmodule // tb_sync_burst_sram_interface
`default_nettype wire
